// >>> tws_params.svh
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// Bus address bytes
`define TWS_BASE1_DEF  8'hD0
`define TWS_BASE2_DEF  8'hD4
`define TWS_ALT_OFS    8'h02
`define TWS_RW_MASK    8'hFE
`define TWS_MC_MASK    8'hF8
`define TWS_MC_CODE    8'h08

// Page control fields
`define TWS_PC_AUTO_RETURN_PAGE_ZERO  7
`define TWS_PC_WMODE   6
`define TWS_PC_PG_HI   2
`define TWS_PC_PG_LO   1
`define TWS_PC_RST     8'h00
`define TWS_PC_LOW     7'h00
`define TWS_WIN_ALT    2'h1

// Supported register ranges, page bits above the byte
`define TWS_R0_LO      10'h050
`define TWS_R0_HI      10'h067
`define TWS_R1_LO      10'h0D0
`define TWS_R1_HI      10'h0DF
`define TWS_R2_LO      10'h140
`define TWS_R2_HI      10'h14F
`define TWS_R3_LO      10'h200
`define TWS_R3_HI      10'h27F

// Timing
`define TWS_CLK_KHZ    100000
`define TWS_TO_MS      35
`define TWS_TO_CYCLES  (`TWS_TO_MS * `TWS_CLK_KHZ)
`define TWS_TO_W       22
`define TWS_HOST_QTR   8
`define TWS_QTR_W      8
`define TWS_BIT_LAST   4'd7
`define TWS_BIT_ACK    4'd8
`define TWS_STEP_STO   4'd8

`endif

// >>> tws_pkg.sv
package tws_pkg;
  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_REG, D_WDATA, D_RDATA, D_SKIP
  } dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE, H_NEXT, H_STA, H_BIT, H_STO
  } host_state_t;
endpackage

// >>> tws_if.sv
`timescale 1ns/1ps
interface tws_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Open drain with pull-ups: a line is low only while someone drives it
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
  modport dev  (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

// >>> two_wire_register_slave.sv
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "tws_params.svh"
module two_wire_register_slave
  import tws_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `TWS_TO_CYCLES
) (
  input  wire logic       sys_clk_i,                      // System clock
  input  wire logic       rst_n_i,                        // Async reset, low
  tws_if.dev              bus,                            // Two-wire pins
  input  wire logic       if_two_wire_i,                  // Two-wire mode
  input  wire logic [7:0] first_base_address_i,           // Base address one
  input  wire logic [7:0] second_base_address_i,          // Base address two
  input  wire logic       address_select_config_i,        // Pin picks base
  input  wire logic       general_input_four_i,           // Address pin
  input  wire logic       bus_idle_timeout_enable_i,      // Stall timeout on
  input  wire logic       continuous_high_speed_enable_i, // Always high speed
  input  wire logic [7:0] reg_rdata_i,                    // Data at reg_addr_o
  output logic            reg_wr_o,                       // Write pulse
  output logic      [9:0] reg_addr_o,                     // Register pointer
  output logic      [7:0] reg_wdata_o,                    // Write data
  output logic      [7:0] page_ctrl_o,                    // Page control
  output logic            hs_mode_o,                      // High speed active
  output logic            gpio_free_o                     // High while two-wire mode is on
);
  logic [2:0] s1_q, s2_q, s3_q;
  logic       scl_q, sda_q, gpi_q, scl_p_q, sda_p_q;
  dev_state_t st_q, nxt_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic       mack_q, hs_q, wm_act_q, pc_wr_q, alt_q, lead_q;
  logic [`TWS_TO_W-1:0] to_q;
  logic       scl_r, scl_f, sta, sto, to_hit, byte_end, ack_end;
  logic [7:0] base, wa, wa2, rbyte;
  logic [1:0] win;
  logic [9:0] ra;
  logic       mc_hit, ra_ok;
  function automatic logic readable(input logic [9:0] a);
    readable = (a >= `TWS_R0_LO && a <= `TWS_R0_HI) ||
               (a >= `TWS_R1_LO && a <= `TWS_R1_HI) ||
               (a >= `TWS_R2_LO && a <= `TWS_R2_HI) ||
               (a >= `TWS_R3_LO && a <= `TWS_R3_HI);
  endfunction
  function automatic logic writable(input logic [9:0] a);
    writable = readable(a) && !(a >= `TWS_R3_LO && a <= `TWS_R3_HI);
  endfunction
  // Pin inputs: a level is taken once the second and third stages agree
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q    <= 3'h7;
      s2_q    <= 3'h7;
      s3_q    <= 3'h7;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      gpi_q   <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      s1_q    <= {general_input_four_i, bus.sda, bus.scl};
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      scl_p_q <= scl_q;
      sda_p_q <= sda_q;
      if (s2_q[0] == s3_q[0]) scl_q <= s3_q[0];
      if (s2_q[1] == s3_q[1]) sda_q <= s3_q[1];
      if (s2_q[2] == s3_q[2]) gpi_q <= s3_q[2];
    end
  end
  assign scl_r    = scl_q & ~scl_p_q;
  assign scl_f    = ~scl_q & scl_p_q;
  assign sta      = scl_q & scl_p_q & sda_p_q & ~sda_q;
  assign sto      = scl_q & scl_p_q & ~sda_p_q & sda_q;
  assign byte_end = scl_f && (cnt_q == `TWS_BIT_LAST);
  assign ack_end  = scl_f && (cnt_q == `TWS_BIT_ACK);
  assign base   = (address_select_config_i && gpi_q) ? second_base_address_i
                                                     : first_base_address_i;
  assign wa     = base & `TWS_RW_MASK;
  assign wa2    = wa + `TWS_ALT_OFS;
  assign mc_hit = (st_q == D_ADDR) && byte_end &&
                  ((sh_q & `TWS_MC_MASK) == `TWS_MC_CODE);
  assign win    = alt_q ? `TWS_WIN_ALT
                        : page_ctrl_o[`TWS_PC_PG_HI:`TWS_PC_PG_LO];
  assign ra     = {win, sh_q};
  assign ra_ok  = (sh_q[6:0] == `TWS_PC_LOW) || readable(ra);
  // Read source: page control, a supported register, or zero
  always_comb begin
    if (reg_addr_o[6:0] == `TWS_PC_LOW) begin
      rbyte = page_ctrl_o;
    end else if (readable(reg_addr_o)) begin
      rbyte = reg_rdata_i;
    end else begin
      rbyte = 8'h00;
    end
  end
  // Byte engine; the data line is only ever pulled low, never the clock
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q          <= D_IDLE;
      nxt_q         <= D_IDLE;
      cnt_q         <= 4'h0;
      sh_q          <= 8'h00;
      mack_q        <= 1'b0;
      alt_q         <= 1'b0;
      lead_q        <= 1'b0;
      bus.dev_sda_oe <= 1'b0;
      reg_wr_o      <= 1'b0;
      pc_wr_q       <= 1'b0;
      reg_addr_o    <= 10'h000;
      reg_wdata_o   <= 8'h00;
    end else begin
      reg_wr_o <= 1'b0;
      pc_wr_q  <= 1'b0;
      if (!if_two_wire_i || to_hit) begin
        st_q           <= D_IDLE;
        bus.dev_sda_oe <= 1'b0;
      end else if (sta) begin
        st_q           <= D_ADDR;
        cnt_q          <= 4'h0;
        lead_q         <= 1'b1;
        bus.dev_sda_oe <= 1'b0;
      end else if (sto) begin
        st_q           <= D_IDLE;
        bus.dev_sda_oe <= 1'b0;
      end else begin
        case (st_q)
          D_ADDR, D_REG, D_WDATA: begin
            if (scl_r && cnt_q != `TWS_BIT_ACK) sh_q <= {sh_q[6:0], sda_q};
            // The clock fall that closes a START carries no bit
            if (scl_f && lead_q) begin
              lead_q <= 1'b0;
            end else if (scl_f && cnt_q < `TWS_BIT_LAST) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (byte_end) begin
              cnt_q <= `TWS_BIT_ACK;
              if (st_q == D_ADDR) begin
                if (sh_q == wa || sh_q == wa2) begin
                  bus.dev_sda_oe <= 1'b1;
                  alt_q          <= (sh_q == wa2);
                  nxt_q          <= D_REG;
                end else if (sh_q == (wa | 8'h01) || sh_q == (wa2 | 8'h01)) begin
                  bus.dev_sda_oe <= 1'b1;
                  nxt_q          <= D_RDATA;
                end else begin
                  nxt_q <= D_SKIP;
                end
              end else if (st_q == D_REG) begin
                bus.dev_sda_oe <= ra_ok;
                reg_addr_o     <= ra;
                nxt_q          <= ra_ok ? D_WDATA : D_SKIP;
              end else begin
                bus.dev_sda_oe <= 1'b1;
                reg_wdata_o    <= sh_q;
                if (reg_addr_o[6:0] == `TWS_PC_LOW) pc_wr_q <= 1'b1;
                else if (writable(reg_addr_o)) reg_wr_o <= 1'b1;
                nxt_q <= wm_act_q ? D_REG : D_WDATA;
              end
            end else if (ack_end) begin
              cnt_q          <= 4'h0;
              st_q           <= nxt_q;
              bus.dev_sda_oe <= 1'b0;
              if (st_q == D_WDATA && !wm_act_q) begin
                reg_addr_o <= {reg_addr_o[9:8], reg_addr_o[7:0] + 8'h01};
              end
              if (nxt_q == D_RDATA) begin
                sh_q           <= rbyte;
                bus.dev_sda_oe <= ~rbyte[7];
              end
            end
          end
          D_RDATA: begin
            if (scl_r && cnt_q == `TWS_BIT_ACK) begin
              mack_q <= ~sda_q;
              if (!sda_q) reg_addr_o <= {reg_addr_o[9:8], reg_addr_o[7:0] + 8'h01};
            end
            if (scl_f && cnt_q < `TWS_BIT_LAST) begin
              cnt_q          <= cnt_q + 4'h1;
              sh_q           <= {sh_q[6:0], 1'b0};
              bus.dev_sda_oe <= ~sh_q[6];
            end else if (byte_end) begin
              cnt_q          <= `TWS_BIT_ACK;
              bus.dev_sda_oe <= 1'b0;
            end else if (ack_end) begin
              if (mack_q) begin
                cnt_q          <= 4'h0;
                sh_q           <= rbyte;
                bus.dev_sda_oe <= ~rbyte[7];
              end else begin
                st_q <= D_SKIP;
              end
            end
          end
          default: begin
            bus.dev_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
  assign bus.dev_sda_o = 1'b0;
  // Page control; write mode only switches at a STOP
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page_ctrl_o <= `TWS_PC_RST;
      wm_act_q    <= 1'b0;
    end else if (pc_wr_q) begin
      page_ctrl_o <= reg_wdata_o;
    end else if (sto && st_q != D_IDLE) begin
      wm_act_q <= page_ctrl_o[`TWS_PC_WMODE];
      if (page_ctrl_o[`TWS_PC_AUTO_RETURN_PAGE_ZERO]) begin
        page_ctrl_o[`TWS_PC_PG_HI:0] <= 3'h0;
      end
    end
  end
  // High speed per transfer or continuously
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_q      <= 1'b0;
      hs_mode_o <= 1'b0;
    end else begin
      if (!if_two_wire_i || sto || to_hit) begin
        hs_q <= 1'b0;
      end else if (mc_hit) begin
        hs_q <= 1'b1;
      end
      hs_mode_o <= hs_q | continuous_high_speed_enable_i;
    end
  end
  // Stalled clock inside a transfer
  assign to_hit = bus_idle_timeout_enable_i &&
                  (to_q == TIMEOUT_CYCLES[`TWS_TO_W-1:0] - 1'b1);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      to_q <= '0;
    end else if (st_q == D_IDLE || scl_r || scl_f || to_hit) begin
      to_q <= '0;
    end else if (bus_idle_timeout_enable_i) begin
      to_q <= to_q + 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gpio_free_o <= 1'b0;
    end else gpio_free_o <= if_two_wire_i;
  end
endmodule

// >>> two_wire_master.sv
`timescale 1ns/1ps
`include "tws_params.svh"
module two_wire_master
  import tws_pkg::*;
(
  input  wire logic       sys_clk_i,   // System clock
  input  wire logic       rst_n_i,     // Async reset, low
  tws_if.host             bus,         // Two-wire pins
  input  wire logic       cmd_valid_i, // Start a transfer
  input  wire logic       cmd_read_i,  // 1 read, 0 write
  input  wire logic       cmd_hs_i,    // Send master code first
  input  wire logic [7:0] cmd_dev_i,   // Write address byte
  input  wire logic [7:0] cmd_reg_i,   // Register address
  input  wire logic [7:0] cmd_data_i,  // Write data
  output logic            busy_o,      // Transfer running
  output logic            done_o,      // Transfer end pulse
  output logic      [7:0] rd_data_o,   // Read data
  output logic            nack_o       // Missing acknowledge seen
);
  logic [2:0] s_q;
  logic       sda_q;
  host_state_t st_q;
  logic [`TWS_QTR_W-1:0] qc_q;
  logic [1:0] ph_q;
  logic [3:0] step_q, cnt_q;
  logic [7:0] sh_q;
  logic       rx_q, mc_q, ackb_q, tick;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q   <= 3'h7;
      sda_q <= 1'b1;
    end else begin
      s_q <= {s_q[1:0], bus.sda};
      if (s_q[1] == s_q[2]) begin
        sda_q <= s_q[2];
      end
    end
  end

  assign tick = (qc_q == `TWS_QTR_W'(`TWS_HOST_QTR - 1));
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      qc_q <= '0;
    end else if (st_q == H_IDLE || st_q == H_NEXT || tick) begin
      qc_q <= '0;
    end else begin
      qc_q <= qc_q + 1'b1;
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;

  // Quarter phases: 0 set data, 1 clock high, 2 sample, 3 clock low
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q            <= H_IDLE;
      ph_q            <= 2'h0;
      step_q          <= 4'h0;
      cnt_q           <= 4'h0;
      sh_q            <= 8'h00;
      rx_q            <= 1'b0;
      mc_q            <= 1'b0;
      ackb_q          <= 1'b0;
      busy_o          <= 1'b0;
      done_o          <= 1'b0;
      rd_data_o       <= 8'h00;
      nack_o          <= 1'b0;
      bus.host_scl_oe <= 1'b0;
      bus.host_sda_oe <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (tick) begin
        ph_q <= ph_q + 2'h1;
      end
      case (st_q)
        H_IDLE: begin
          ph_q <= 2'h0;
          if (cmd_valid_i) begin
            busy_o <= 1'b1;
            nack_o <= 1'b0;
            step_q <= 4'h0;
            st_q   <= H_NEXT;
          end
        end
        H_NEXT: begin
          cnt_q  <= 4'h0;
          rx_q   <= 1'b0;
          mc_q   <= 1'b0;
          step_q <= step_q + 4'h1;
          st_q   <= H_BIT;
          case (step_q)
            4'd0: st_q <= H_STA;
            4'd1: begin
              sh_q <= `TWS_MC_CODE;
              mc_q <= 1'b1;
              if (!cmd_hs_i) st_q <= H_NEXT;
            end
            4'd2: st_q <= cmd_hs_i ? H_STA : H_NEXT;
            4'd3: sh_q <= cmd_dev_i & `TWS_RW_MASK;
            4'd4: sh_q <= cmd_reg_i;
            4'd5: begin
              sh_q <= cmd_data_i;
              if (cmd_read_i) st_q <= H_STA;
            end
            4'd6: begin
              sh_q <= cmd_dev_i | 8'h01;
              if (!cmd_read_i) st_q <= H_STO;
            end
            4'd7: rx_q <= 1'b1;
            default: st_q <= H_STO;
          endcase
        end
        H_STA: if (tick) begin
          case (ph_q)
            2'd0: bus.host_sda_oe <= 1'b0;
            2'd1: bus.host_scl_oe <= 1'b0;
            2'd2: bus.host_sda_oe <= 1'b1;
            default: begin
              bus.host_scl_oe <= 1'b1;
              st_q            <= H_NEXT;
            end
          endcase
        end
        H_BIT: if (tick) begin
          case (ph_q)
            2'd0: begin
              if (cnt_q == `TWS_BIT_ACK) begin
                bus.host_sda_oe <= 1'b0;
              end else begin
                bus.host_sda_oe <= !rx_q && !sh_q[7];
              end
            end
            2'd1: bus.host_scl_oe <= 1'b0;
            2'd2: begin
              if (cnt_q == `TWS_BIT_ACK) begin
                ackb_q <= sda_q;
              end else if (rx_q) begin
                sh_q <= {sh_q[6:0], sda_q};
              end
            end
            default: begin
              bus.host_scl_oe <= 1'b1;
              if (cnt_q != `TWS_BIT_ACK) begin
                cnt_q <= cnt_q + 4'h1;
                if (!rx_q) sh_q <= {sh_q[6:0], 1'b0};
              end else if (rx_q) begin
                rd_data_o <= sh_q;
                st_q      <= H_STO;
              end else if (ackb_q && !mc_q) begin
                nack_o <= 1'b1;
                st_q   <= H_STO;
              end else begin
                st_q <= H_NEXT;
              end
            end
          endcase
        end
        H_STO: if (tick) begin
          case (ph_q)
            2'd0: bus.host_sda_oe <= 1'b1;
            2'd1: bus.host_scl_oe <= 1'b0;
            2'd2: bus.host_sda_oe <= 1'b0;
            default: begin
              busy_o <= 1'b0;
              done_o <= 1'b1;
              st_q   <= H_IDLE;
            end
          endcase
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end
endmodule

// >>> tws_monitor.sv
`timescale 1ns/1ps
module tws_monitor #(
  parameter logic [7:0] BASE = 8'hD0
) (
  input  wire logic sys_clk_i,   // System clock
  input  wire logic rst_n_i,     // Async reset, low
  input  wire logic host_sda_oe, // Host pulls data
  input  wire logic dev_sda_oe,  // Device pulls data
  input  wire logic scl,         // Clock wire
  input  wire logic sda          // Data wire
);
  logic       scl_q, sda_q, rd_q;
  logic [3:0] bit_q;
  logic [7:0] byte_q, sh_q, addr_q, low_q;
  wire rise  = scl && !scl_q;
  wire start = scl && scl_q && sda_q && !sda;
  wire stop  = scl && scl_q && !sda_q && sda;
  wire match = (addr_q & 8'hFC) == BASE;
  // Wire history and time since the clock went low
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {scl_q, sda_q} <= 2'b11;
      low_q <= 8'h00;
    end else begin
      {scl_q, sda_q} <= {scl, sda};
      low_q <= scl ? 8'h00 : low_q + {7'h00, low_q != 8'hFF};
    end
  end
  // Bit and byte position inside the frame
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {bit_q, byte_q, sh_q, addr_q, rd_q} <= '0;
    end else if (start || stop) begin
      {bit_q, byte_q, rd_q} <= '0;
    end else if (rise) begin
      if (bit_q == 4'd8) begin
        bit_q  <= 4'd0;
        byte_q <= byte_q + 8'h01;
      end else begin
        bit_q <= bit_q + 4'd1;
        sh_q  <= {sh_q[6:0], sda};
      end
      if (bit_q == 4'd7 && byte_q == 8'h00) begin
        addr_q <= {sh_q[6:0], sda};
        rd_q   <= sda;
      end
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_dev_change_low; $changed(dev_sda_oe) |-> !scl; endproperty
  property p_dev_delay; $changed(dev_sda_oe) |-> low_q >= 8'd2 && low_q <= 8'd9; endproperty
  property p_high_stable; $rose(scl) |=> $stable(dev_sda_oe)[*6]; endproperty
  property p_foreign_quiet;
    rise && bit_q == 4'd8 && byte_q == 8'h00 && !match |-> !dev_sda_oe;
  endproperty
  property p_own_ack; rise && bit_q == 4'd8 && byte_q == 8'h00 && match && rd_q |-> dev_sda_oe;
  endproperty
  property p_write_quiet; rise && !rd_q && bit_q != 4'd8 |-> !dev_sda_oe; endproperty
  property p_read_release; rise && rd_q && byte_q != 8'h00 && bit_q == 4'd8 |-> !dev_sda_oe;
  endproperty
  property p_host_start; $rose(host_sda_oe) && scl |-> $past(sda); endproperty
  property p_stop_quiet; stop |=> !dev_sda_oe[*4]; endproperty
  a_dev_change_low: assert property (p_dev_change_low) else $error("data moved in high");
  a_dev_delay: assert property (p_dev_delay) else $error("late device data");
  a_high_stable: assert property (p_high_stable) else $error("data unstable");
  a_foreign_quiet: assert property (p_foreign_quiet) else $error("foreign ack");
  a_own_ack: assert property (p_own_ack) else $error("own address not acked");
  a_write_quiet: assert property (p_write_quiet) else $error("device drove data");
  a_read_release: assert property (p_read_release) else $error("host ack blocked");
  a_host_start: assert property (p_host_start) else $error("start not from high");
  a_stop_quiet: assert property (p_stop_quiet) else $error("driven after stop");
  c_ack: cover property (rise && bit_q == 4'd8 && byte_q == 8'h00 && dev_sda_oe);
  c_read: cover property (rise && rd_q && byte_q == 8'h01);
  c_stop: cover property (stop);
endmodule

// >>> two_wire_register_slave_test.sv
`timescale 1ns/1ps
module two_wire_register_slave_test;
  logic       clk, rst_n, cv, crd, chs, two, sel, gpi, hs_c, to_en, hs_seen, br;
  logic [7:0] cdev, creg, cdat, b1, b2, mem [0:1023];
  logic [9:0] a1, a2;
  logic [7:0] d1, d2, rd, pc;
  logic       w1, w2, done, nack, hs, gfree, busy;
  integer     err_count, tests_run;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
  tws_if bus_if();
  tws_if bus2();
  two_wire_master u_two_wire_master (.sys_clk_i(clk), .rst_n_i(rst_n), .bus(bus_if),
    .cmd_valid_i(cv), .cmd_read_i(crd), .cmd_hs_i(chs), .cmd_dev_i(cdev), .cmd_reg_i(creg),
    .cmd_data_i(cdat), .busy_o(busy), .done_o(done), .rd_data_o(rd), .nack_o(nack));
  two_wire_register_slave #(.TIMEOUT_CYCLES(200)) u_two_wire_register_slave (
    .sys_clk_i(clk), .rst_n_i(rst_n), .bus(bus_if), .if_two_wire_i(two),
    .first_base_address_i(b1), .second_base_address_i(b2), .address_select_config_i(sel),
    .general_input_four_i(gpi), .bus_idle_timeout_enable_i(to_en),
    .continuous_high_speed_enable_i(hs_c), .reg_rdata_i(mem[a1]), .reg_wr_o(w1),
    .reg_addr_o(a1), .reg_wdata_o(d1), .page_ctrl_o(pc), .hs_mode_o(hs), .gpio_free_o(gfree));
  two_wire_register_slave #(.TIMEOUT_CYCLES(200)) u_two_wire_register_slave_b (
    .sys_clk_i(clk), .rst_n_i(rst_n), .bus(bus2), .if_two_wire_i(two),
    .first_base_address_i(b1), .second_base_address_i(b2), .address_select_config_i(sel),
    .general_input_four_i(gpi), .bus_idle_timeout_enable_i(to_en),
    .continuous_high_speed_enable_i(hs_c), .reg_rdata_i(mem[a2]), .reg_wr_o(w2),
    .reg_addr_o(a2), .reg_wdata_o(d2), .page_ctrl_o(), .hs_mode_o(), .gpio_free_o());
  tws_monitor u_tws_monitor (.sys_clk_i(clk), .rst_n_i(rst_n), .host_sda_oe(bus_if.host_sda_oe),
    .dev_sda_oe(bus_if.dev_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (w1) mem[a1] <= d1;
    if (w2) mem[a2] <= d2;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  // One host transfer; en is the expected missing-acknowledge flag
  task automatic mc(input logic r, h, input logic [7:0] dv, rg, dt, input logic en);
    integer n;
    crd <= r; chs <= h; cdev <= dv; creg <= rg; cdat <= dt; cv <= 1'b1;
    @(posedge clk);
    cv <= 1'b0;
    hs_seen = 1'b0;
    for (n = 0; n < 20000 && done !== 1'b1; n++) begin
      @(posedge clk);
      if (hs === 1'b1) hs_seen = 1'b1;
    end
    if (n == 20000) err_count++;
    `CHK(busy, 1'b0)
    `CHK(nack, en)
  endtask
  task automatic w8;
    repeat (8) @(posedge clk);
  endtask
  // Hand-driven second bus: quarter-bit phases of 8 clocks
  task automatic bb_bit(input logic b, output logic r);
    bus2.host_sda_oe <= ~b; w8; bus2.host_scl_oe <= 1'b0; w8;
    r = bus2.sda; w8; bus2.host_scl_oe <= 1'b1; w8;
  endtask
  task automatic bb_start;
    bus2.host_sda_oe <= 1'b0; w8; bus2.host_scl_oe <= 1'b0; w8;
    bus2.host_sda_oe <= 1'b1; w8; bus2.host_scl_oe <= 1'b1; w8;
  endtask
  task automatic bb_stop;
    bus2.host_sda_oe <= 1'b1; w8; bus2.host_scl_oe <= 1'b0; w8; bus2.host_sda_oe <= 1'b0; w8;
  endtask
  task automatic bb_tx(input logic [7:0] d, input logic e);
    logic r;
    for (int i = 7; i >= 0; i--) bb_bit(d[i], r);
    bb_bit(1'b1, r);
    `CHK(r, e)
  endtask
  task automatic bb_rx(input logic last, input logic [7:0] e);
    logic r;
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) begin
      bb_bit(1'b1, r);
      d = {d[6:0], r};
    end
    bb_bit(last, r);
    `CHK(d, e)
  endtask
  initial begin
    #900us;
    err_count++;
    wrap_up;
  end
  initial begin
    {rst_n, cv, crd, chs, sel, gpi, hs_c} = '0;
    {cdev, creg, cdat} = '0;
    {two, to_en, b1, b2} = {2'b11, 8'hD0, 8'hD4};
    {err_count, tests_run} = '0;
    {bus2.host_scl_o, bus2.host_sda_o, bus2.host_scl_oe, bus2.host_sda_oe} = 4'h0;
    for (int i = 0; i < 1024; i++) mem[i] = 8'hEE;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    mc(0, 0, 8'hD0, 8'h51, 8'h3C, 0);
    `CHK(mem[10'h051], 8'h3C)
    `CHK(hs_seen, 1'b0)
    mc(1, 0, 8'hD0, 8'h51, 8'h00, 0);
    `CHK(rd, 8'h3C)
    mc(0, 0, 8'hA0, 8'h52, 8'h77, 1);
    mc(0, 0, 8'hD0, 8'h30, 8'h77, 1);
    `CHK(mem[10'h052], 8'hEE)
    tend("basic");
    mc(0, 0, 8'hD2, 8'h40, 8'h5A, 0);
    `CHK(mem[10'h140], 8'h5A)
    mc(0, 0, 8'hD0, 8'h00, 8'h03, 0);
    `CHK(pc, 8'h03)
    mc(0, 0, 8'hD0, 8'h41, 8'h11, 0);
    `CHK(mem[10'h141], 8'h11)
    mc(1, 0, 8'hD0, 8'h00, 8'h00, 0);
    `CHK(rd, 8'h03)
    mc(0, 0, 8'hD0, 8'h00, 8'h82, 0);
    mc(1, 0, 8'hD0, 8'h00, 8'h00, 0);
    `CHK(pc[2:0], 3'h0)
    tend("paging");
    b1 <= 8'hD8; b2 <= 8'hD0; sel <= 1'b1; gpi <= 1'b1;
    mc(0, 0, 8'hD0, 8'h53, 8'h21, 0);
    gpi <= 1'b0;
    mc(0, 0, 8'hD0, 8'h53, 8'h22, 1);
    `CHK(mem[10'h053], 8'h21)
    b1 <= 8'hD0; sel <= 1'b0; two <= 1'b0;
    mc(0, 0, 8'hD0, 8'h54, 8'h01, 1);
    `CHK(gfree, 1'b0)
    two <= 1'b1;
    mc(0, 1, 8'hD0, 8'h54, 8'h02, 0);
    `CHK(hs_seen, 1'b1)
    `CHK(gfree, 1'b1)
    hs_c <= 1'b1;
    mc(0, 0, 8'hD0, 8'h55, 8'h03, 0);
    `CHK(hs_seen, 1'b1)
    hs_c <= 1'b0;
    tend("modes");
    bb_start; bb_tx(8'hD0, 0); bb_tx(8'h65, 0); bb_tx(8'h01, 0); bb_tx(8'h02, 0);
    bb_tx(8'h03, 0); bb_stop;
    `CHK(mem[10'h067], 8'h03)
    bb_start; bb_tx(8'hD0, 0); bb_tx(8'h66, 0); bb_start; bb_tx(8'hD1, 0);
    bb_rx(0, 8'h02); bb_rx(0, 8'h03);
    bb_rx(1, 8'h00); bb_stop;
    bb_start; bb_tx(8'hD0, 0); bb_tx(8'h00, 0); bb_tx(8'h40, 0); bb_stop;
    bb_start; bb_tx(8'hD0, 0); bb_tx(8'h5E, 0); bb_tx(8'hAA, 0); bb_tx(8'h60, 0);
    bb_tx(8'hBB, 0); bb_stop;
    `CHK(mem[10'h05E], 8'hAA)
    `CHK(mem[10'h060], 8'hBB)
    bb_start; bb_tx(8'hD0, 0); bb_tx(8'h00, 0); bb_tx(8'h00, 0); bb_stop;
    tend("burst");
    bb_start; bb_tx(8'hD0, 0); bb_tx(8'h5C, 0);
    repeat (4) bb_bit(1'b1, br);
    bb_start; bb_tx(8'hD0, 0); bb_stop;
    `CHK(mem[10'h05C], 8'hEE)
    // Freeze the clock high while the device holds its acknowledge
    bb_start;
    for (int i = 7; i >= 0; i--) bb_bit(cdev[i], br);
    bus2.host_sda_oe <= 1'b0; w8; bus2.host_scl_oe <= 1'b0; w8;
    `CHK(bus2.sda, 1'b0)
    repeat (300) @(posedge clk);
    `CHK(bus2.sda, 1'b1)
    bus2.host_scl_oe <= 1'b1; w8; bb_stop;
    tend("abort");
    wrap_up;
  end
endmodule
